// ==== core/ssm_pkg.sv ====
package ssm_pkg;

	localparam int unsigned AXI_AW   = 8;
	localparam int unsigned DATA_W   = 32;
	localparam int unsigned N_IN_TRM = 4;
	localparam int unsigned N_IN_FN  = 2;
	localparam int unsigned N_OUT_TRM = 4;
	localparam int unsigned N_OUT_FN = 4;
	localparam int unsigned SPEED_W  = 16;

	localparam logic [AXI_AW-1:0] OFS_CTRL     = 8'h00;
	localparam logic [AXI_AW-1:0] OFS_THRESH   = 8'h04;
	localparam logic [AXI_AW-1:0] OFS_IN_MAP   = 8'h08;
	localparam logic [AXI_AW-1:0] OFS_OUT_MAP  = 8'h0c;
	localparam logic [AXI_AW-1:0] OFS_STATUS   = 8'h10;
	localparam logic [AXI_AW-1:0] OFS_IRQ_STAT = 8'h14;
	localparam logic [AXI_AW-1:0] OFS_IRQ_MASK = 8'h18;

	localparam int unsigned CTRL_CODE_LSB = 0;
	localparam int unsigned CTRL_CODE_W   = 4;
	localparam int unsigned CTRL_CLR_BIT  = 8;

	localparam int unsigned MAP_MODE_LSB  = 0;
	localparam int unsigned MAP_CLR_LSB   = 4;

	localparam int unsigned FN_IN_MODE = 0;
	localparam int unsigned FN_IN_CLR  = 1;

	localparam int unsigned FN_OUT_NORMAL = 0;
	localparam int unsigned FN_OUT_ROT    = 1;
	localparam int unsigned FN_OUT_BRAKE  = 2;
	localparam int unsigned FN_OUT_READY  = 3;

	localparam int unsigned ST_MODE_LSB  = 0;
	localparam int unsigned ST_ALARM     = 3;
	localparam int unsigned ST_ENC_ALARM = 4;
	localparam int unsigned ST_ROT       = 5;
	localparam int unsigned ST_READY     = 6;
	localparam int unsigned ST_POWER     = 7;
	localparam int unsigned ST_TIN_LSB   = 8;
	localparam int unsigned ST_TOUT_LSB  = 12;

	localparam int unsigned IRQ_W         = 4;
	localparam int unsigned IRQ_ALM_SET   = 0;
	localparam int unsigned IRQ_ALM_CLR   = 1;
	localparam int unsigned IRQ_MODE_CHG  = 2;
	localparam int unsigned IRQ_ROT_START = 3;

	localparam logic [CTRL_CODE_W-1:0] RST_CODE     = 4'h7;
	localparam logic [SPEED_W-1:0]     RST_THRESH   = 16'h0014;
	localparam logic [7:0]             RST_IN_MAP   = 8'h21;
	localparam logic [15:0]            RST_OUT_MAP  = 16'h8421;
	localparam logic [IRQ_W-1:0]       RST_IRQ_MASK = 4'h0;

	localparam logic [CTRL_CODE_W-1:0] CODE_POS_SPD  = 4'h7;
	localparam logic [CTRL_CODE_W-1:0] CODE_POS_TRQ  = 4'h8;
	localparam logic [CTRL_CODE_W-1:0] CODE_TRQ_SPD  = 4'h9;
	localparam logic [CTRL_CODE_W-1:0] CODE_SPD_ZCLP = 4'ha;
	localparam logic [CTRL_CODE_W-1:0] CODE_POS_INH  = 4'hb;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		SSM_MODE_OTHER,
		SSM_MODE_POSITION,
		SSM_MODE_SPEED,
		SSM_MODE_TORQUE,
		SSM_MODE_ZERO_CLAMP,
		SSM_MODE_PULSE_INHIBIT
	} ssm_mode_e;

endpackage : ssm_pkg

// ==== core/ssm_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module ssm_sync #(
	parameter int unsigned  W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);

	logic [W-1:0] meta_r;

	// The first stage feeds only the second stage; the reset value is fixed so reset never samples a pin.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_r <= RST_VAL;
			q      <= RST_VAL;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule : ssm_sync

`default_nettype wire

// ==== core/ssm_or_map.sv ====
`timescale 1ns/1ps
`default_nettype none

module ssm_or_map #(
	parameter int unsigned N_SRC = 4,
	parameter int unsigned N_DST = 4
) (
	input  wire logic [N_SRC-1:0]       src_on,
	input  wire logic [N_DST*N_SRC-1:0] dst_mask,
	output var  logic [N_DST-1:0]       dst_on
);

	// Every source selected for a destination is ORed into it, so sharing is allowed but never exclusive.
	for (genvar j = 0; j < N_DST; j++) begin : g_dst
		assign dst_on[j] = |(src_on & dst_mask[j*N_SRC +: N_SRC]);
	end

endmodule : ssm_or_map

`default_nettype wire

// ==== core/ssm_servo_io.sv ====
`timescale 1ns/1ps
`default_nettype none

// How it works
// RULE1: For mode-pair codes 7 to B the active control mode is chosen by the level of the mode-switch input.
// RULE2: With mode-switch low codes 7,8,9,A,B give speed, torque, speed, zero clamp, pulse inhibit; high gives position, position, torque, speed, position.
// RULE3: The alarm output is low in normal operation and high while any alarm is active.
// RULE4: An alarm is cleared only by a high-to-low edge of the alarm-clear input, never by a held low level.
// RULE5: Alarm clear comes from a mapped input terminal, the panel or the operator unit, and has no setting that holds it permanently asserted.
// RULE6: The terminal carrying the alarm-clear input is chosen by a writable input map.
// RULE7: A clear request from the panel or the operator unit also clears the alarm.
// RULE8: Encoder alarms survive the clear edge and go away only at a control power cycle.
// RULE9: The rotation output is low while motor speed exceeds the threshold and high otherwise.
// RULE10: Output functions mapped to the same terminal are combined by OR.
// RULE11: The ready output is low only while main power is on and no alarm is active.
// RULE12: Input functions that share one terminal each see it, the terminals of a function being ORed.
// RULE13: The input terminals and the main-power input are synchronised before levels or edges are taken from them.
module ssm_servo_io
	import ssm_pkg::*;
(
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	input  wire logic [ssm_pkg::AXI_AW-1:0]    s_axil_awaddr,
	input  wire logic                          s_axil_awvalid,
	output logic                               s_axil_awready,
	input  wire logic [ssm_pkg::DATA_W-1:0]    s_axil_wdata,
	input  wire logic [ssm_pkg::DATA_W/8-1:0]  s_axil_wstrb,
	input  wire logic                          s_axil_wvalid,
	output logic                               s_axil_wready,
	output logic [1:0]                         s_axil_bresp,
	output logic                               s_axil_bvalid,
	input  wire logic                          s_axil_bready,
	input  wire logic [ssm_pkg::AXI_AW-1:0]    s_axil_araddr,
	input  wire logic                          s_axil_arvalid,
	output logic                               s_axil_arready,
	output logic [ssm_pkg::DATA_W-1:0]         s_axil_rdata,
	output logic [1:0]                         s_axil_rresp,
	output logic                               s_axil_rvalid,
	input  wire logic                          s_axil_rready,
	input  wire logic [ssm_pkg::N_IN_TRM-1:0]  in_term_n,
	input  wire logic                          main_power_on,
	input  wire logic                          panel_clear,
	input  wire logic                          fault_set,
	input  wire logic                          enc_fault_set,
	input  wire logic [ssm_pkg::SPEED_W-1:0]   motor_speed,
	input  wire logic                          brake_release,
	output logic [2:0]                         active_mode,
	output logic                               alarm_out,
	output logic                               rotating_out_n,
	output logic                               brake_out_n,
	output logic                               servo_ready_out_n,
	output logic [ssm_pkg::N_OUT_TRM-1:0]      out_term_n,
	output logic                               irq
);

	import ssm_pkg::*;

	function automatic logic [DATA_W-1:0] merge_bytes(
		input logic [DATA_W-1:0]   old_v,
		input logic [DATA_W-1:0]   new_v,
		input logic [DATA_W/8-1:0] strb
	);
		logic [DATA_W-1:0] r;
		r = old_v;
		for (int b = 0; b < DATA_W/8; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction : merge_bytes

	// Register state.
	logic [CTRL_CODE_W-1:0]         code_r;
	logic [SPEED_W-1:0]             thresh_r;
	logic [7:0]                     in_map_r;
	logic [15:0]                    out_map_r;
	logic [IRQ_W-1:0]               irq_stat_r;
	logic [IRQ_W-1:0]               irq_mask_r;
	logic                           sw_clear_r;

	// Bus state.
	logic                           aw_hold_r;
	logic [AXI_AW-1:0]              awaddr_r;
	logic                           w_hold_r;
	logic [DATA_W-1:0]              wdata_r;
	logic [DATA_W/8-1:0]            wstrb_r;
	logic                           bvalid_r;
	logic [1:0]                     bresp_r;
	logic                           rvalid_r;
	logic [1:0]                     rresp_r;
	logic [DATA_W-1:0]              rdata_r;
	logic                           wr_fire;
	logic                           rd_fire;
	logic [DATA_W-1:0]              wr_merged;
	logic [DATA_W-1:0]              rd_value;
	logic                           rd_hit;

	// Datapath state.
	logic [N_IN_TRM-1:0]            term_n_s;
	logic                           power_s;
	logic [N_IN_TRM-1:0]            term_on;
	logic [N_IN_FN-1:0]             fn_in_on;
	logic                           clr_level_prev_r;
	logic                           clr_edge;
	logic                           clear_req;
	logic                           alarm_gen_r;
	logic                           alarm_enc_r;
	logic                           alarm_any;
	ssm_mode_e                      mode_nxt;
	ssm_mode_e                      mode_r;
	logic                           rotating;
	logic                           rot_prev_r;
	logic                           alarm_prev_r;
	logic [N_OUT_FN-1:0]            fn_out_on;
	logic [N_OUT_TRM-1:0]           term_out_on;
	logic [IRQ_W-1:0]               irq_event;

	// Input conditioning.
	ssm_sync #(
		.W(N_IN_TRM + 1),
		.RST_VAL({1'b0, {N_IN_TRM{1'b1}}})
	) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       ({main_power_on, in_term_n}),
		.q       ({power_s, term_n_s})
	); // RULE13

	assign term_on = ~term_n_s;

	ssm_or_map #(
		.N_SRC(N_IN_TRM),
		.N_DST(N_IN_FN)
	) u_in_map (
		.src_on   (term_on),
		.dst_mask (in_map_r),
		.dst_on   (fn_in_on)
	); // RULE6 RULE12

	// A clear only counts on the transition into the on state, so a held low never repeats it.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clr_level_prev_r <= 1'b0;
		end else begin
			clr_level_prev_r <= fn_in_on[FN_IN_CLR];
		end
	end

	assign clr_edge  = fn_in_on[FN_IN_CLR] && !clr_level_prev_r; // RULE4 RULE5
	assign clear_req = clr_edge || panel_clear || sw_clear_r; // RULE7

	// Control mode selection.
	always_comb begin
		mode_nxt = SSM_MODE_OTHER;
		unique case (code_r)
			CODE_POS_SPD:  mode_nxt = fn_in_on[FN_IN_MODE] ? SSM_MODE_SPEED : SSM_MODE_POSITION; // RULE1 RULE2
			CODE_POS_TRQ:  mode_nxt = fn_in_on[FN_IN_MODE] ? SSM_MODE_TORQUE : SSM_MODE_POSITION; // RULE2
			CODE_TRQ_SPD:  mode_nxt = fn_in_on[FN_IN_MODE] ? SSM_MODE_SPEED : SSM_MODE_TORQUE; // RULE2
			CODE_SPD_ZCLP: mode_nxt = fn_in_on[FN_IN_MODE] ? SSM_MODE_ZERO_CLAMP : SSM_MODE_SPEED; // RULE2
			CODE_POS_INH:  mode_nxt = fn_in_on[FN_IN_MODE] ? SSM_MODE_PULSE_INHIBIT : SSM_MODE_POSITION; // RULE2
			default:       mode_nxt = SSM_MODE_OTHER;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_r <= SSM_MODE_OTHER;
		end else begin
			mode_r <= mode_nxt;
		end
	end

	assign active_mode = mode_r;

	// Alarm latches; a new fault in the clearing cycle keeps the alarm set.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			alarm_gen_r <= 1'b0;
		end else if (fault_set) begin
			alarm_gen_r <= 1'b1;
		end else if (clear_req) begin
			alarm_gen_r <= 1'b0; // RULE4 RULE7
		end
	end

	// Only the power-on reset removes an encoder alarm.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			alarm_enc_r <= 1'b0;
		end else if (enc_fault_set) begin
			alarm_enc_r <= 1'b1; // RULE8
		end
	end

	assign alarm_any = alarm_gen_r || alarm_enc_r;
	assign rotating  = motor_speed > thresh_r; // RULE9

	// Output functions, each one on when its pin sits low.
	assign fn_out_on[FN_OUT_NORMAL] = !alarm_any;
	assign fn_out_on[FN_OUT_ROT]    = rotating;
	assign fn_out_on[FN_OUT_BRAKE]  = brake_release;
	assign fn_out_on[FN_OUT_READY]  = power_s && !alarm_any; // RULE11

	ssm_or_map #(
		.N_SRC(N_OUT_FN),
		.N_DST(N_OUT_TRM)
	) u_out_map (
		.src_on   (fn_out_on),
		.dst_mask (out_map_r),
		.dst_on   (term_out_on)
	); // RULE10

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			alarm_out         <= 1'b0;
			rotating_out_n    <= 1'b1;
			brake_out_n       <= 1'b1;
			servo_ready_out_n <= 1'b1;
			out_term_n        <= {N_OUT_TRM{1'b1}};
		end else begin
			alarm_out         <= alarm_any; // RULE3
			rotating_out_n    <= !fn_out_on[FN_OUT_ROT]; // RULE9
			brake_out_n       <= !fn_out_on[FN_OUT_BRAKE];
			servo_ready_out_n <= !fn_out_on[FN_OUT_READY]; // RULE11
			out_term_n        <= ~term_out_on; // RULE10
		end
	end

	// Interrupt events.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rot_prev_r   <= 1'b0;
			alarm_prev_r <= 1'b0;
		end else begin
			rot_prev_r   <= rotating;
			alarm_prev_r <= alarm_any;
		end
	end

	assign irq_event[IRQ_ALM_SET]   = alarm_any && !alarm_prev_r;
	assign irq_event[IRQ_ALM_CLR]   = !alarm_any && alarm_prev_r;
	assign irq_event[IRQ_MODE_CHG]  = mode_nxt != mode_r;
	assign irq_event[IRQ_ROT_START] = rotating && !rot_prev_r;

	// AXI4-Lite write path: address and data are caught separately and joined.
	assign s_axil_awready = !aw_hold_r;
	assign s_axil_wready  = !w_hold_r;
	assign wr_fire        = aw_hold_r && w_hold_r && !bvalid_r;
	assign s_axil_bvalid  = bvalid_r;
	assign s_axil_bresp   = bresp_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r <= 1'b0;
			awaddr_r  <= '0;
		end else if (s_axil_awvalid && s_axil_awready) begin
			aw_hold_r <= 1'b1;
			awaddr_r  <= s_axil_awaddr;
		end else if (wr_fire) begin
			aw_hold_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_hold_r <= 1'b0;
			wdata_r  <= '0;
			wstrb_r  <= '0;
		end else if (s_axil_wvalid && s_axil_wready) begin
			w_hold_r <= 1'b1;
			wdata_r  <= s_axil_wdata;
			wstrb_r  <= s_axil_wstrb;
		end else if (wr_fire) begin
			w_hold_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r  <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_r <= 1'b1;
			unique case ({awaddr_r[AXI_AW-1:2], 2'b00})
				OFS_CTRL, OFS_THRESH, OFS_IN_MAP, OFS_OUT_MAP, OFS_STATUS, OFS_IRQ_STAT, OFS_IRQ_MASK:
					bresp_r <= RESP_OKAY;
				default:
					bresp_r <= RESP_SLVERR;
			endcase
		end else if (s_axil_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	always_comb begin
		wr_merged = '0;
		unique case ({awaddr_r[AXI_AW-1:2], 2'b00})
			OFS_CTRL:    wr_merged = merge_bytes({23'h0, sw_clear_r, 4'h0, code_r}, wdata_r, wstrb_r);
			OFS_THRESH:  wr_merged = merge_bytes({16'h0, thresh_r}, wdata_r, wstrb_r);
			OFS_IN_MAP:  wr_merged = merge_bytes({24'h0, in_map_r}, wdata_r, wstrb_r);
			OFS_OUT_MAP: wr_merged = merge_bytes({16'h0, out_map_r}, wdata_r, wstrb_r);
			OFS_IRQ_MASK: wr_merged = merge_bytes({28'h0, irq_mask_r}, wdata_r, wstrb_r);
			default:     wr_merged = merge_bytes('0, wdata_r, wstrb_r);
		endcase
	end

	// Configuration registers.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			code_r     <= RST_CODE;
			thresh_r   <= RST_THRESH;
			in_map_r   <= RST_IN_MAP;
			out_map_r  <= RST_OUT_MAP;
			irq_mask_r <= RST_IRQ_MASK;
		end else if (wr_fire) begin
			unique case ({awaddr_r[AXI_AW-1:2], 2'b00})
				OFS_CTRL:     code_r     <= wr_merged[CTRL_CODE_LSB +: CTRL_CODE_W];
				OFS_THRESH:   thresh_r   <= wr_merged[SPEED_W-1:0];
				OFS_IN_MAP:   in_map_r   <= wr_merged[7:0]; // RULE6
				OFS_OUT_MAP:  out_map_r  <= wr_merged[15:0];
				OFS_IRQ_MASK: irq_mask_r <= wr_merged[IRQ_W-1:0];
				default:      code_r     <= code_r;
			endcase
		end
	end

	// The operator clear is a one-cycle pulse and cannot be left standing on.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sw_clear_r <= 1'b0;
		end else begin
			sw_clear_r <= wr_fire && ({awaddr_r[AXI_AW-1:2], 2'b00} == OFS_CTRL)
				&& wstrb_r[CTRL_CLR_BIT/8] && wdata_r[CTRL_CLR_BIT]; // RULE5 RULE7
		end
	end

	// Sticky status; an event in the cycle of its write-one clear stays set.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_r <= '0;
		end else if (wr_fire && ({awaddr_r[AXI_AW-1:2], 2'b00} == OFS_IRQ_STAT) && wstrb_r[0]) begin
			irq_stat_r <= (irq_stat_r & ~wdata_r[IRQ_W-1:0]) | irq_event;
		end else begin
			irq_stat_r <= irq_stat_r | irq_event;
		end
	end

	assign irq = |(irq_stat_r & irq_mask_r);

	// AXI4-Lite read path.
	assign s_axil_arready = !rvalid_r;
	assign rd_fire        = s_axil_arvalid && s_axil_arready;
	assign s_axil_rvalid  = rvalid_r;
	assign s_axil_rdata   = rdata_r;
	assign s_axil_rresp   = rresp_r;

	always_comb begin
		rd_value = '0;
		rd_hit   = 1'b1;
		unique case ({s_axil_araddr[AXI_AW-1:2], 2'b00})
			OFS_CTRL:     rd_value[CTRL_CODE_LSB +: CTRL_CODE_W] = code_r;
			OFS_THRESH:   rd_value[SPEED_W-1:0] = thresh_r;
			OFS_IN_MAP:   rd_value[7:0] = in_map_r;
			OFS_OUT_MAP:  rd_value[15:0] = out_map_r;
			OFS_STATUS: begin
				rd_value[ST_MODE_LSB +: 3]          = mode_r;
				rd_value[ST_ALARM]                  = alarm_any;
				rd_value[ST_ENC_ALARM]              = alarm_enc_r;
				rd_value[ST_ROT]                    = rotating;
				rd_value[ST_READY]                  = fn_out_on[FN_OUT_READY];
				rd_value[ST_POWER]                  = power_s;
				rd_value[ST_TIN_LSB +: N_IN_TRM]    = term_n_s;
				rd_value[ST_TOUT_LSB +: N_OUT_TRM]  = out_term_n;
			end
			OFS_IRQ_STAT: rd_value[IRQ_W-1:0] = irq_stat_r;
			OFS_IRQ_MASK: rd_value[IRQ_W-1:0] = irq_mask_r;
			default:      rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rresp_r  <= RESP_OKAY;
			rdata_r  <= '0;
		end else if (rd_fire) begin
			rvalid_r <= 1'b1;
			rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			rdata_r  <= rd_value;
		end else if (s_axil_rready) begin
			rvalid_r <= 1'b0;
		end
	end

endmodule : ssm_servo_io

`default_nettype wire

// ==== test/ssm_servo_io_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module ssm_servo_io_assertions
	import ssm_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axil_wvalid,
	input wire logic        s_axil_wready,
	input wire logic        s_axil_bvalid,
	input wire logic        s_axil_bready,
	input wire logic [1:0]  s_axil_bresp,
	input wire logic [3:0]  in_term_n,
	input wire logic        main_power_on,
	input wire logic        panel_clear,
	input wire logic        fault_set,
	input wire logic        enc_fault_set,
	input wire logic [15:0] motor_speed,
	input wire logic [2:0]  active_mode,
	input wire logic        alarm_out,
	input wire logic        rotating_out_n,
	input wire logic        servo_ready_out_n
);
	logic [2:0] since_r;
	logic [1:0] enc_r;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Any possible clear source restarts the window, so a held level cannot keep clearing.
	// Reset is a power cycle and clears the alarm too.
	always_ff @(posedge aclk) begin
		if (!aresetn)
			since_r <= 3'h0;
		else if (panel_clear || (s_axil_wvalid && s_axil_wready) || (|($past(in_term_n) & ~in_term_n)))
			since_r <= 3'h0;
		else if (since_r != 3'h7)
			since_r <= since_r + 3'h1;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn)
			enc_r <= 2'h0;
		else
			enc_r <= {enc_r[0], enc_r[0] | enc_fault_set};
	end
	property p_fault_alarm;
		fault_set |-> ##[1:2] alarm_out;
	endproperty
	a_fault_alarm: assert property (p_fault_alarm) else $error("alarm not raised");
	property p_clear_cause;
		$fell(alarm_out) |-> since_r < 3'h7;
	endproperty
	a_clear_cause: assert property (p_clear_cause) else $error("alarm cleared without a clear event");
	property p_enc_hold;
		enc_r[1] |-> alarm_out;
	endproperty
	a_enc_hold: assert property (p_enc_hold) else $error("encoder alarm lost");
	property p_ready_alarm;
		!servo_ready_out_n |-> !alarm_out;
	endproperty
	a_ready_alarm: assert property (p_ready_alarm) else $error("ready during alarm");
	property p_ready_power;
		!servo_ready_out_n |-> $past(main_power_on, 3);
	endproperty
	a_ready_power: assert property (p_ready_power) else $error("ready without power");
	property p_mode_range;
		active_mode <= 3'h5;
	endproperty
	a_mode_range: assert property (p_mode_range) else $error("mode out of range");
	property p_rot_speed;
		!rotating_out_n |-> ($past(motor_speed) | $past(motor_speed, 2)) != 16'h0000;
	endproperty
	a_rot_speed: assert property (p_rot_speed) else $error("rotating at zero speed");
	property p_bresp_hold;
		s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid && $stable(s_axil_bresp);
	endproperty
	a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped");
endmodule : ssm_servo_io_assertions
bind ssm_servo_io ssm_servo_io_assertions i_chk (
	.aclk, .aresetn, .s_axil_wvalid, .s_axil_wready, .s_axil_bvalid, .s_axil_bready, .s_axil_bresp,
	.in_term_n, .main_power_on, .panel_clear, .fault_set, .enc_fault_set, .motor_speed, .active_mode,
	.alarm_out, .rotating_out_n, .servo_ready_out_n
);
`default_nettype wire

// ==== test/ssm_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ssm_host_model (
	input  wire logic       aclk,
	input  wire logic [3:0] term_on,
	output var  logic [3:0] in_term_n
);
	// Contacts switch just after an edge, never on it, so the synchronisers see clean levels.
	initial in_term_n = 4'hf;
	always @(posedge aclk) in_term_n <= ~term_on;
endmodule : ssm_host_model
`default_nettype wire

// ==== test/ssm_servo_io_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module ssm_servo_io_tb;
	import ssm_pkg::*;
	logic        aclk, aresetn, s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready;
	logic        s_axil_bvalid, s_axil_bready, s_axil_arvalid, s_axil_arready, s_axil_rvalid;
	logic        s_axil_rready, main_power_on, panel_clear, fault_set, enc_fault_set, brake_release;
	logic        alarm_out, rotating_out_n, brake_out_n, servo_ready_out_n, irq;
	logic [7:0]  s_axil_awaddr, s_axil_araddr;
	logic [31:0] s_axil_wdata, s_axil_rdata, rdv;
	logic [3:0]  s_axil_wstrb, term_on, in_term_n, out_term_n;
	logic [1:0]  s_axil_bresp, s_axil_rresp, rsp;
	logic [2:0]  active_mode;
	logic [15:0] motor_speed, rnd;
	int          errors, num_checks, cyc, s, b;
	int          m_lo[5] = '{2, 3, 2, 4, 5};
	int          m_hi[5] = '{1, 1, 3, 2, 1};
	int          ofs[6] = '{0, 4, 8, 12, 24, 32};
	int          rv[6] = '{7, 20, 'h21, 'h8421, 0, 0};
	ssm_servo_io i_dut (
		.aclk, .aresetn, .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready, .s_axil_wdata, .s_axil_wstrb,
		.s_axil_wvalid, .s_axil_wready, .s_axil_bresp, .s_axil_bvalid, .s_axil_bready, .s_axil_araddr,
		.s_axil_arvalid, .s_axil_arready, .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid, .s_axil_rready,
		.in_term_n, .main_power_on, .panel_clear, .fault_set, .enc_fault_set, .motor_speed, .brake_release,
		.active_mode, .alarm_out, .rotating_out_n, .brake_out_n, .servo_ready_out_n, .out_term_n, .irq
	);
	ssm_host_model i_host (.aclk, .term_on, .in_term_n);
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : lfsr
	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk
	task automatic cy(input int n);
		repeat (n) @(posedge aclk);
	endtask : cy
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ad, dd;
		ad = 1'b0;
		dd = 1'b0;
		@(posedge aclk);
		s_axil_awaddr <= a;
		s_axil_wdata <= d;
		s_axil_awvalid <= 1'b1;
		s_axil_wvalid <= 1'b1;
		s_axil_bready <= 1'b1;
		while (!(ad && dd)) begin
			@(posedge aclk);
			ad = ad | s_axil_awready;
			dd = dd | s_axil_wready;
			s_axil_awvalid <= !ad;
			s_axil_wvalid <= !dd;
		end
		do @(posedge aclk); while (s_axil_bvalid !== 1'b1);
		rsp = s_axil_bresp;
		s_axil_bready <= 1'b0;
	endtask : wr
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge aclk);
		s_axil_araddr <= a;
		s_axil_arvalid <= 1'b1;
		s_axil_rready <= 1'b1;
		do @(posedge aclk); while (s_axil_arready !== 1'b1);
		s_axil_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axil_rvalid !== 1'b1);
		rdv = s_axil_rdata;
		rsp = s_axil_rresp;
		s_axil_rready <= 1'b0;
		chk(rdv, e, "read data");
		chk(rsp, er, "read resp");
	endtask : rchk
	task automatic pulse_fault();
		fault_set <= 1'b1;
		cy(1);
		fault_set <= 1'b0;
		cy(4);
	endtask : pulse_fault
	task automatic press(input int t);
		term_on[t] <= 1'b1;
		cy(8);
		term_on[t] <= 1'b0;
		cy(4);
	endtask : press
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 10000) begin
			errors++;
			finish_test();
		end
	end
	initial begin
		{aresetn, s_axil_awvalid, s_axil_wvalid, s_axil_bready, s_axil_arvalid, s_axil_rready} = 6'h00;
		{panel_clear, fault_set, enc_fault_set, brake_release} = 4'h0;
		s_axil_awaddr = 8'h00;
		s_axil_araddr = 8'h00;
		s_axil_wdata = 32'h0;
		s_axil_wstrb = 4'hf;
		term_on = 4'h0;
		motor_speed = 16'h0000;
		main_power_on = 1'b1;
		rnd = 16'h001e;
		cy(12);
		aresetn <= 1'b1;
		for (int i = 0; i < 6; i++)
			rchk(ofs[i], rv[i], (i == 5) ? RESP_SLVERR : RESP_OKAY);
		wr(8'h20, 32'h1);
		chk(rsp, RESP_SLVERR, "unmapped write");
		chk(servo_ready_out_n, 1'b0, "ready");
		main_power_on <= 1'b0;
		cy(5);
		chk(servo_ready_out_n, 1'b1, "ready off");
		main_power_on <= 1'b1;
		for (int c = 7; c < 12; c++) begin
			for (int sw = 0; sw < 2; sw++) begin
				wr(OFS_CTRL, c);
				term_on[0] <= sw[0];
				cy(6);
				chk(active_mode, sw ? m_lo[c - 7] : m_hi[c - 7], "mode");
			end
		end
		wr(OFS_CTRL, 32'h3);
		cy(3);
		chk(active_mode, 3'h0, "mode other");
		term_on[0] <= 1'b0;
		wr(OFS_CTRL, 32'h7);
		wr(OFS_IRQ_STAT, 32'hf);
		pulse_fault();
		chk(alarm_out, 1'b1, "alarm");
		chk(servo_ready_out_n, 1'b1, "ready in alarm");
		chk(irq, 1'b0, "irq masked");
		rchk(OFS_IRQ_STAT, 32'h1, RESP_OKAY);
		wr(OFS_IRQ_MASK, 32'h1);
		chk(irq, 1'b1, "irq");
		wr(OFS_IRQ_STAT, 32'h1);
		chk(irq, 1'b0, "irq cleared");
		term_on[1] <= 1'b1;
		cy(8);
		chk(alarm_out, 1'b0, "pin clear");
		pulse_fault();
		cy(8);
		chk(alarm_out, 1'b1, "held low");
		term_on[1] <= 1'b0;
		cy(8);
		chk(alarm_out, 1'b1, "release");
		press(1);
		chk(alarm_out, 1'b0, "second edge");
		wr(OFS_IN_MAP, 32'hc1);
		pulse_fault();
		press(1);
		chk(alarm_out, 1'b1, "old terminal");
		press(3);
		chk(alarm_out, 1'b0, "new terminal");
		wr(OFS_IN_MAP, 32'h01);
		pulse_fault();
		for (int t = 0; t < 4; t++)
			press(t);
		chk(alarm_out, 1'b1, "no clear terminal");
		wr(OFS_IN_MAP, 32'h21);
		panel_clear <= 1'b1;
		cy(1);
		panel_clear <= 1'b0;
		cy(4);
		chk(alarm_out, 1'b0, "panel clear");
		pulse_fault();
		wr(OFS_CTRL, 32'h107);
		cy(3);
		chk(alarm_out, 1'b0, "operator clear");
		rchk(OFS_CTRL, 32'h7, RESP_OKAY);
		wr(OFS_THRESH, 32'd100);
		wr(OFS_OUT_MAP, 32'h8426);
		for (int i = 0; i < 10; i++) begin
			rnd = lfsr(rnd);
			s = (i < 2) ? 100 + i : 40 + rnd[6:0];
			b = rnd[7];
			motor_speed <= s[15:0];
			brake_release <= b[0];
			cy(4);
			chk(rotating_out_n, !(s > 100), "rotating");
			chk(out_term_n[0], !((s > 100) || b), "shared terminal");
			chk(brake_out_n, !b[0], "brake");
			chk(out_term_n[3:1], {1'b0, !b[0], !(s > 100)}, "other terminals");
		end
		enc_fault_set <= 1'b1;
		cy(1);
		enc_fault_set <= 1'b0;
		press(1);
		wr(OFS_CTRL, 32'h107);
		cy(3);
		chk(alarm_out, 1'b1, "encoder alarm");
		aresetn <= 1'b0;
		cy(2);
		aresetn <= 1'b1;
		cy(4);
		chk(alarm_out, 1'b0, "power cycle");
		rchk(OFS_STATUS, {16'h0, 1'b0, !b[0], 2'b00, 12'hfe1}, RESP_OKAY);
		finish_test();
	end
endmodule : ssm_servo_io_tb
`default_nettype wire
